// [rtl/swc_pkg.sv]
// package: standby controller constants and types
package swc_pkg;
    // ==========================================
    // run and standby modes
    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_IDLE,
        SWC_DEEP,
        SWC_XTAL
    } swc_mode_t;

    // ==========================================
    // widths, mode command codes, reset values and reset pulse length
    localparam int          SWC_PORT_W     = 8;
    localparam logic [1:0]  SWC_CMD_IDLE   = 2'h1;
    localparam logic [1:0]  SWC_CMD_DEEP   = 2'h2;
    localparam logic [1:0]  SWC_CMD_XTAL   = 2'h3;
    localparam logic [7:0]  SWC_DIR_RST    = 8'h00;
    localparam logic [7:0]  SWC_PULL_RST   = 8'h00;
    localparam logic [7:0]  SWC_DOUT_RST   = 8'h00;
    localparam int          SWC_RST_PULSE  = 4;
endpackage : swc_pkg

// [rtl/swc_port.sv]
// one 8-bit port: direction, pull-up, pin readback
`timescale 1ns/1ns
`default_nettype none
module swc_port (
    input  wire logic                           clock_in,
    input  wire logic                           rst_in,
    input  wire logic                           wr_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] dout_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] dir_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] pull_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] pin_in,
    output logic      [swc_pkg::SWC_PORT_W-1:0] pin_out,
    output logic      [swc_pkg::SWC_PORT_W-1:0] pin_oe_out,
    output logic      [swc_pkg::SWC_PORT_W-1:0] pull_en_out,
    output logic      [swc_pkg::SWC_PORT_W-1:0] rd_out
);
    import swc_pkg::*;
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] dir;
        logic [7:0] pull;
        logic [7:0] s1;
        logic [7:0] s2;
    } swc_port_st_t;
    swc_port_st_t st_r;
    swc_port_st_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        if (wr_in) begin
            st_nxt.dout = dout_in;
            st_nxt.dir  = dir_in;
            st_nxt.pull = pull_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '{SWC_DOUT_RST, SWC_DIR_RST, SWC_PULL_RST, 8'h00, 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out     = st_r.dout;
    assign pin_oe_out  = st_r.dir;
    assign pull_en_out = st_r.pull;
    // pin level, never the output latch
    assign rd_out      = st_r.s2;

    // two edges of history must lie after reset before the pipe is full
    rd_follows_pin_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (!$past(rst_in) && !$past(rst_in, 2)) |-> rd_out == $past(pin_in, 2))
        else $error("port read does not follow pin");
endmodule : swc_port
`default_nettype wire

// [rtl/swc_top.sv]
// standby wake controller: idle, deep and crystal-retaining standby
`timescale 1ns/1ns
`default_nettype none
module swc_top (
    input  wire logic                           clock_in,
    input  wire logic                           rst_in,
    input  wire logic                           mode_wr_in,
    input  wire logic [1:0]                     mode_sel_in,
    input  wire logic                           pll_en_in,
    input  wire logic                           ceramic_osc_en_in,
    input  wire logic                           mrc_en_in,
    input  wire logic                           xtal_en_in,
    input  wire logic                           wdt_lrc_en_in,
    input  wire logic                           bt_uses_lrc_in,
    input  wire logic                           reset_pin_n_in,
    input  wire logic                           wdt_reset_in,
    input  wire logic                           low_voltage_reset_in,
    input  wire logic                           irq_any_in,
    input  wire logic                           ext_irq_pin_a_in,
    input  wire logic                           ext_irq_pin_b_in,
    input  wire logic                           ext_irq_pin_c_in,
    input  wire logic                           ext_irq_pin_e_in,
    input  wire logic                           ext_irq_pin_f_in,
    input  wire logic                           pin_a_level_in,
    input  wire logic                           pin_b_level_in,
    input  wire logic                           port0_irq_in,
    input  wire logic                           usb_bus_active_in,
    input  wire logic                           base_timer_irq_in,
    input  wire logic                           ir_rx_irq_in,
    input  wire logic                           port_wr_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] port_dout_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] port_dir_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] port_pull_in,
    input  wire logic [swc_pkg::SWC_PORT_W-1:0] port_pin_in,
    output logic      [swc_pkg::SWC_PORT_W-1:0] port_pin_out,
    output logic      [swc_pkg::SWC_PORT_W-1:0] port_oe_out,
    output logic      [swc_pkg::SWC_PORT_W-1:0] port_pull_en_out,
    output logic      [swc_pkg::SWC_PORT_W-1:0] port_rd_out,
    output logic                                reset_pin_n_out,
    output logic                                reset_pin_oe_out,
    output logic                                chip_reset_out,
    output logic                                cpu_run_out,
    output logic                                periph_run_out,
    output logic                                bt_ir_run_out,
    output logic                                pll_run_out,
    output logic                                ceramic_osc_run_out,
    output logic                                mrc_run_out,
    output logic                                xtal_run_out,
    output logic                                lrc_run_out,
    output logic [1:0]                          mode_out
);
    import swc_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        swc_mode_t  mode;
        logic [1:0] rsync;
        logic       pll;
        logic       cer;
        logic       mrc;
        logic       xtal;
        logic       lrc;
        logic       xtal_hold;
        logic       lrc_hold;
        logic [2:0] rcnt;
        logic       rdrive;
        logic       crst;
        logic       cpu;
        logic       per;
        logic       btir;
    } swc_st_t;
    swc_st_t st_r;
    swc_st_t st_nxt;

    logic pin_low;
    logic rst_src;
    logic deep_wake;
    logic xtal_wake;

    assign pin_low = !st_r.rsync[1];
    assign rst_src = pin_low || wdt_reset_in || low_voltage_reset_in;

    // edge-detect pins a and b cannot wake: no clock to see the edge
    assign deep_wake = rst_src
        || (ext_irq_pin_a_in && pin_a_level_in)
        || (ext_irq_pin_b_in && pin_b_level_in)
        || ext_irq_pin_c_in || ext_irq_pin_e_in
        || ext_irq_pin_f_in || port0_irq_in || usb_bus_active_in;
    assign xtal_wake = deep_wake || base_timer_irq_in
        || ir_rx_irq_in;

    // ==========================================
    // next state
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rsync    = {st_r.rsync[0], reset_pin_n_in};
        st_nxt.crst     = rst_src || st_r.rdrive;
        st_nxt.lrc      = wdt_lrc_en_in;
        case (st_r.mode)
            SWC_RUN: begin
                st_nxt.pll  = pll_en_in;
                st_nxt.cer  = ceramic_osc_en_in;
                st_nxt.mrc  = mrc_en_in;
                st_nxt.xtal = xtal_en_in;
                if (mode_wr_in) begin
                    case (mode_sel_in)
                        SWC_CMD_IDLE: st_nxt.mode = SWC_IDLE;
                        SWC_CMD_DEEP: begin
                            st_nxt.mode = SWC_DEEP;
                            st_nxt.pll  = 1'b0;
                            st_nxt.cer  = 1'b0;
                            st_nxt.mrc  = 1'b0;
                            st_nxt.xtal = 1'b0;
                        end
                        SWC_CMD_XTAL: begin
                            st_nxt.mode      = SWC_XTAL;
                            st_nxt.pll       = 1'b0;
                            st_nxt.cer       = 1'b0;
                            st_nxt.mrc       = 1'b0;
                            st_nxt.xtal      = xtal_en_in;
                            st_nxt.xtal_hold = xtal_en_in;
                            st_nxt.lrc_hold  = wdt_lrc_en_in;
                        end
                        default: st_nxt.mode = SWC_RUN;
                    endcase
                end
            end
            SWC_IDLE: begin
                // oscillators other than the low-speed rc keep their entry state
                if (rst_src || irq_any_in) begin
                    st_nxt.mode = SWC_RUN;
                end
            end
            SWC_DEEP: begin
                if (deep_wake) begin
                    st_nxt.mode = SWC_RUN;
                end
            end
            SWC_XTAL: begin
                st_nxt.xtal = st_r.xtal_hold;
                if (bt_uses_lrc_in) begin
                    st_nxt.lrc = st_r.lrc_hold;
                end
                if (xtal_wake) begin
                    st_nxt.mode = SWC_RUN;
                end
            end
            default: st_nxt.mode = SWC_RUN;
        endcase
        // watchdog or low-voltage reset stretched onto the pin
        if (wdt_reset_in || low_voltage_reset_in) begin
            st_nxt.rcnt   = 3'(SWC_RST_PULSE);
            st_nxt.rdrive = 1'b1;
        end else if (st_r.rcnt != 3'h0) begin
            st_nxt.rcnt = st_r.rcnt - 3'h1;
        end else begin
            st_nxt.rdrive = 1'b0;
        end
        // run enables registered so the outputs come from flops
        st_nxt.cpu  = (st_nxt.mode == SWC_RUN);
        st_nxt.per  = st_nxt.cpu || (st_nxt.mode == SWC_IDLE);
        st_nxt.btir = st_nxt.per || (st_nxt.mode == SWC_XTAL);
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '{SWC_RUN, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                      1'b0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // outputs
    assign mode_out            = st_r.mode;
    assign cpu_run_out         = st_r.cpu;
    assign periph_run_out      = st_r.per;
    assign bt_ir_run_out       = st_r.btir;
    assign pll_run_out         = st_r.pll;
    assign ceramic_osc_run_out = st_r.cer;
    assign mrc_run_out         = st_r.mrc;
    assign xtal_run_out        = st_r.xtal;
    assign lrc_run_out         = st_r.lrc;
    assign reset_pin_n_out     = 1'b0;
    assign reset_pin_oe_out    = st_r.rdrive;
    assign chip_reset_out      = st_r.crst;

    // ==========================================
    // general port; filter pins left as inputs by software
    swc_port u_port (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .wr_in       (port_wr_in),
        .dout_in     (port_dout_in),
        .dir_in      (port_dir_in),
        .pull_in     (port_pull_in),
        .pin_in      (port_pin_in),
        .pin_out     (port_pin_out),
        .pin_oe_out  (port_oe_out),
        .pull_en_out (port_pull_en_out),
        .rd_out      (port_rd_out)
    );

    // ==========================================
    // checks
    idle_wake_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_IDLE && irq_any_in) |=> cpu_run_out)
        else $error("idle did not wake on interrupt");
    idle_periph_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_IDLE) |-> periph_run_out && !cpu_run_out)
        else $error("idle gating wrong");
    idle_osc_keep_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_IDLE) |=> $stable({pll_run_out,
        ceramic_osc_run_out, mrc_run_out, xtal_run_out}))
        else $error("oscillator changed in idle");
    deep_osc_off_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_DEEP) |-> !pll_run_out && !xtal_run_out
        && !mrc_run_out && !ceramic_osc_run_out && !periph_run_out)
        else $error("oscillator running in deep standby");
    deep_wake_usb_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_DEEP && usb_bus_active_in) |=> cpu_run_out)
        else $error("deep standby missed usb wake");
    edge_no_wake_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_DEEP && !deep_wake) |=> !cpu_run_out)
        else $error("deep standby woke without source");
    // judged from the pins, not from the wake decode it guards
    pin_ab_edge_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_DEEP && !pin_a_level_in && !pin_b_level_in
        && !rst_src && !ext_irq_pin_c_in && !ext_irq_pin_e_in
        && !ext_irq_pin_f_in && !port0_irq_in && !usb_bus_active_in)
        |=> !cpu_run_out)
        else $error("edge-detect pin woke deep standby");
    xtal_hold_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_XTAL) |-> xtal_run_out == st_r.xtal_hold
        && bt_ir_run_out && !periph_run_out)
        else $error("crystal standby state wrong");
    lrc_wdt_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode != SWC_XTAL) |=> lrc_run_out == $past(wdt_lrc_en_in))
        else $error("low-speed rc not following watchdog");
    xtal_bt_wake_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        (st_r.mode == SWC_XTAL && base_timer_irq_in) |=> cpu_run_out)
        else $error("crystal standby missed timer wake");
    rst_drive_a: assert property (@(posedge clock_in)
        disable iff (rst_in)
        $rose(wdt_reset_in) |=> reset_pin_oe_out [*4])
        else $error("reset pin not driven");
endmodule : swc_top
`default_nettype wire

// [verif/swc_far_model.sv]
// far-side model: reset pin wire and external port pin drivers
`timescale 1ns/1ns
`default_nettype none
module swc_far_model (
    input  wire logic       hold_rst_in,
    input  wire logic       rst_oe_in,
    input  wire logic       rst_drv_in,
    input  wire logic [7:0] port_oe_in,
    input  wire logic [7:0] port_drv_in,
    input  wire logic [7:0] ext_in,
    output logic            rst_level_out,
    output logic [7:0]      port_level_out
);
    // ======================================
    // wire resolution
    // pulled up; low if either party pulls it down
    assign rst_level_out = !(hold_rst_in || (rst_oe_in && !rst_drv_in));
    // outside driver always present, so no floating bits
    assign port_level_out = (port_oe_in & port_drv_in)
                          | (~port_oe_in & ext_in);
endmodule : swc_far_model
`default_nettype wire

// [verif/standby_wake_controller_test.sv]
// testbench for the standby wake controller
`timescale 1ns/1ns
`default_nettype none
module standby_wake_controller_test;
    import swc_pkg::*;
    logic clock_in = 0, rst_in = 1, mode_wr = 0, port_wr = 0;
    logic [1:0] sel = 0;
    logic pll_en = 1, cer_en = 0, mrc_en = 1, xtal_en = 1;
    logic lrc_en = 1, bt_lrc = 0, hold_rst = 0, pa_lvl = 1, pb_lvl = 1;
    logic [11:0] src = 0;
    logic [7:0] dout = 0, dir = 0, pull = 0, ext = 8'h3c;
    logic [7:0] p_out, p_oe, p_pull, p_rd, p_lvl;
    logic rpn_out, rp_oe, rp_lvl, chip_rst, cpu, per, btir;
    logic pll, cer, mrc, xtal, lrc;
    logic [1:0] mode;
    int err_count = 0, comparisons = 0, cyc = 0;

    swc_top dut_u (.clock_in(clock_in), .rst_in(rst_in),
        .mode_wr_in(mode_wr), .mode_sel_in(sel), .pll_en_in(pll_en),
        .ceramic_osc_en_in(cer_en), .mrc_en_in(mrc_en),
        .xtal_en_in(xtal_en), .wdt_lrc_en_in(lrc_en),
        .bt_uses_lrc_in(bt_lrc), .reset_pin_n_in(rp_lvl),
        .wdt_reset_in(src[9]), .low_voltage_reset_in(src[10]),
        .irq_any_in(src[0]), .ext_irq_pin_a_in(src[1]),
        .ext_irq_pin_b_in(src[2]), .ext_irq_pin_c_in(src[3]),
        .ext_irq_pin_e_in(src[4]), .ext_irq_pin_f_in(src[5]),
        .pin_a_level_in(pa_lvl), .pin_b_level_in(pb_lvl),
        .port0_irq_in(src[6]), .usb_bus_active_in(src[7]),
        .base_timer_irq_in(src[8]), .ir_rx_irq_in(src[11]),
        .port_wr_in(port_wr), .port_dout_in(dout), .port_dir_in(dir),
        .port_pull_in(pull), .port_pin_in(p_lvl), .port_pin_out(p_out),
        .port_oe_out(p_oe), .port_pull_en_out(p_pull),
        .port_rd_out(p_rd), .reset_pin_n_out(rpn_out),
        .reset_pin_oe_out(rp_oe), .chip_reset_out(chip_rst),
        .cpu_run_out(cpu), .periph_run_out(per), .bt_ir_run_out(btir),
        .pll_run_out(pll), .ceramic_osc_run_out(cer),
        .mrc_run_out(mrc), .xtal_run_out(xtal), .lrc_run_out(lrc),
        .mode_out(mode));
    swc_far_model far_u (.hold_rst_in(hold_rst), .rst_oe_in(rp_oe),
        .rst_drv_in(rpn_out), .port_oe_in(p_oe), .port_drv_in(p_out),
        .ext_in(ext), .rst_level_out(rp_lvl), .port_level_out(p_lvl));

    always #5 clock_in = ~clock_in;
    // ======================================
    // hang guard: whole run is well under a thousand cycles
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            complete_run();
        end
    end
    // ======================================
    // helpers
    task chk(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task enter(input logic [1:0] c);
        @(posedge clock_in) begin mode_wr <= 1; sel <= c; end
        @(posedge clock_in) mode_wr <= 0;
        #1 chk("mode", 8'(mode), 8'(c));
    endtask : enter
    task try_wake(input logic [1:0] c, input int i, input logic w);
        enter(c);
        @(posedge clock_in) src[i] <= 1;
        tick(4);
        chk("wake", 8'(mode), w ? 8'h00 : 8'(c));
        @(posedge clock_in) src[i] <= 0;
        // a source that did not wake: leave through the bus event
        if (!w) begin
            @(posedge clock_in) src[7] <= 1;
            @(posedge clock_in) src[7] <= 0;
        end
        tick(16);
    endtask : try_wake
    // ======================================
    // scenarios
    task t_idle;
        chk("rst_mode", 8'(mode), 8'h00);
        enter(2'h0);
        enter(SWC_CMD_IDLE);
        chk("idle_cpu", 8'({cpu, per}), 8'h01);
        chk("idle_osc", 8'({pll, cer, mrc, xtal}), 8'h0b);
        @(posedge clock_in) begin mode_wr <= 1; sel <= SWC_CMD_DEEP; end
        @(posedge clock_in) mode_wr <= 0;
        tick(1);
        chk("idle_refuse", 8'(mode), 8'(SWC_CMD_IDLE));
        @(posedge clock_in) src[0] <= 1;
        tick(4);
        chk("idle_wake", 8'(mode), 8'h00);
        @(posedge clock_in) src[0] <= 0;
        try_wake(SWC_CMD_IDLE, 10, 1);
        try_wake(SWC_CMD_IDLE, 9, 1);
    endtask : t_idle
    task t_deep;
        enter(SWC_CMD_DEEP);
        chk("deep_run", 8'({cpu, per, btir}), 8'h00);
        chk("deep_osc", 8'({pll, cer, mrc, xtal}), 8'h00);
        @(posedge clock_in) lrc_en <= 0;
        tick(3);
        chk("deep_lrc0", 8'(lrc), 8'h00);
        @(posedge clock_in) lrc_en <= 1;
        tick(3);
        chk("deep_lrc1", 8'(lrc), 8'h01);
        @(posedge clock_in) src[7] <= 1;
        @(posedge clock_in) src[7] <= 0;
        tick(4);
        chk("wake_osc", 8'({pll, cer, mrc, xtal}), 8'h0b);
        for (int i = 1; i < 8; i++) try_wake(SWC_CMD_DEEP, i, 1);
        try_wake(SWC_CMD_DEEP, 10, 1);
        try_wake(SWC_CMD_DEEP, 0, 0);
        try_wake(SWC_CMD_DEEP, 8, 0);
        try_wake(SWC_CMD_DEEP, 11, 0);
        @(posedge clock_in) begin pa_lvl <= 0; pb_lvl <= 0; end
        try_wake(SWC_CMD_DEEP, 1, 0);
        try_wake(SWC_CMD_DEEP, 2, 0);
        try_wake(SWC_CMD_XTAL, 1, 0);
        try_wake(SWC_CMD_XTAL, 2, 0);
    endtask : t_deep
    task t_xtal;
        @(posedge clock_in) bt_lrc <= 1;
        enter(SWC_CMD_XTAL);
        chk("xtal_run", 8'({cpu, per, btir}), 8'h01);
        chk("xtal_osc", 8'({pll, cer, mrc}), 8'h00);
        @(posedge clock_in) begin xtal_en <= 0; lrc_en <= 0; end
        tick(4);
        chk("xtal_keep", 8'(xtal), 8'h01);
        chk("lrc_keep", 8'(lrc), 8'h01);
        @(posedge clock_in) begin xtal_en <= 1; lrc_en <= 1; end
        @(posedge clock_in) src[8] <= 1;
        tick(4);
        chk("bt_wake", 8'(mode), 8'h00);
        @(posedge clock_in) src[8] <= 0;
        tick(2);
        try_wake(SWC_CMD_XTAL, 6, 1);
        // crystal stopped at entry, low-speed rc left to the watchdog
        @(posedge clock_in) begin bt_lrc <= 0; xtal_en <= 0; end
        enter(SWC_CMD_XTAL);
        @(posedge clock_in) begin xtal_en <= 1; lrc_en <= 0; end
        tick(3);
        chk("xtal_off_keep", 8'({xtal, lrc}), 8'h00);
        @(posedge clock_in) lrc_en <= 1;
        @(posedge clock_in) src[11] <= 1;
        tick(4);
        chk("ir_wake", 8'(mode), 8'h00);
        @(posedge clock_in) src[11] <= 0;
        tick(2);
    endtask : t_xtal
    task t_rstpin;
        @(posedge clock_in) src[9] <= 1;
        @(posedge clock_in) src[9] <= 0;
        tick(2);
        chk("pin_drive", 8'({rp_oe, rpn_out, chip_rst}), 8'h05);
        tick(20);
        chk("pin_free", 8'({rp_oe, chip_rst}), 8'h00);
        enter(SWC_CMD_DEEP);
        @(posedge clock_in) hold_rst <= 1;
        tick(4);
        chk("pin_wake", 8'(mode), 8'h00);
        chk("pin_sense", 8'(chip_rst), 8'h01);
        @(posedge clock_in) hold_rst <= 0;
        tick(20);
        chk("pin_idle", 8'({rp_oe, chip_rst}), 8'h00);
    endtask : t_rstpin
    task t_port;
        // filter-pin bits 3 and 4 stay inputs
        @(posedge clock_in) begin
            port_wr <= 1;
            dout <= 8'ha5;
            dir <= 8'h27;
            pull <= 8'hf0;
        end
        @(posedge clock_in) port_wr <= 0;
        tick(3);
        chk("port_oe", p_oe, 8'h27);
        chk("port_pull", p_pull, 8'hf0);
        chk("port_out", p_out & 8'h27, 8'h25);
        chk("port_rd", p_rd, 8'h3d);
        @(posedge clock_in) ext <= 8'hc3;
        tick(3);
        chk("port_rd2", p_rd, 8'he5);
    endtask : t_port
    task complete_run;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        tick(8);
        @(posedge clock_in) rst_in <= 0;
        tick(2);
        t_idle();
        t_deep();
        t_xtal();
        t_rstpin();
        t_port();
        complete_run();
    end
endmodule : standby_wake_controller_test
`default_nettype wire
